/* hw/psdl_loader.sv */
// Function
// R1 - port 2 rate bit defaults from speed strap: low 10, high 100 Mbps
// R2 - port 2 duplex bit defaults from duplex strap: low half, high full
// R3 - port 2 backpressure enable defaults from backpressure strap
// R4 - port 2 tx and rx pause enables both default from one strap
// R5 - port 2 manual flow select defaults from its strap
// R6 - virtual partner ability from port 0 speed, polarity strap, duplex pin
// R7 - port 0 fallback speed after failed negotiation follows speed strap
// R8 - port 0 full duplex when duplex pin equals polarity strap
// R9 - straps sampled once after reset release, later pin changes ignored
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module psdl_loader (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // strap pins, port 0 duplex pin and port 0 negotiation-failed flag
  input  wire psdl_pkg::psdl_straps_t straps_in,
  input  wire logic                   port0_duplex_pin,
  input  wire logic                   port0_aneg_failed,
  // register port
  input  wire psdl_pkg::psdl_req_t    req,
  output logic                 [15:0] rdata,
  // control outputs
  output psdl_pkg::psdl_basic_t       port2_basic_control_reg,
  output psdl_pkg::psdl_flow_t        port2_flow,
  output logic                        port0_speed_100,
  output logic                        port0_full_duplex,
  output logic                 [3:0]  virtual_partner_ability_reg,
  output logic                        straps_loaded
);

  typedef struct packed {
    psdl_pkg::psdl_basic_t basic;
    psdl_pkg::psdl_flow_t  flow;
    logic                  p0_speed;
    logic                  p0_full;
    logic [3:0]            ability;
    logic [15:0]           rdata;
    logic                  loaded;
    logic                  seeded;
  } psdl_state_t;

  psdl_state_t            state;
  psdl_state_t            next_state;
  psdl_pkg::psdl_straps_t straps;
  logic                   cap_loaded;
  logic                   dup_full;
  logic [3:0]             ability_w;

  // ==========================================================================
  // strap capture
  psdl_capture u_cap (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .straps_in (straps_in),
    .straps    (straps),
    .loaded    (cap_loaded)
  );

  // match means full duplex
  assign dup_full = (port0_duplex_pin == straps.p0_duplex_polarity); // R8

  psdl_ability u_ab (
    .speed_strap (straps.p0_speed),
    .duplex_full (dup_full),
    .ability     (ability_w)
  );

  // ==========================================================================
  // register defaults, software writes, port 0 speed
  always_comb begin
    next_state = state;
    next_state.loaded = cap_loaded;
    next_state.p0_full = dup_full;
    next_state.ability = ability_w; // R6
    // defaults loaded once; seeded never drops so later strap moves are moot
    if (cap_loaded && !state.seeded) begin
      next_state.seeded = 1'b1;
      next_state.basic.rate_select_low_bit = straps.p2_speed; // R1
      next_state.basic.duplex_mode_bit = straps.p2_duplex; // R2
      next_state.flow.port2_backpressure_enable = straps.p2_backpressure; // R3
      next_state.flow.port2_tx_pause_enable = straps.p2_pause; // R4
      next_state.flow.port2_rx_pause_enable = straps.p2_pause; // R4
      next_state.flow.port2_manual_flow_select = straps.p2_manual_flow; // R5
    end else if (req.wr) begin
      unique case (req.addr)
        psdl_pkg::OFS_P2_BASIC: begin
          next_state.basic.rate_select_low_bit = req.wdata[psdl_pkg::BIT_RATE];
          next_state.basic.duplex_mode_bit = req.wdata[psdl_pkg::BIT_DUPLEX];
        end
        psdl_pkg::OFS_P2_FLOW: begin
          next_state.flow.port2_backpressure_enable = req.wdata[psdl_pkg::BIT_BP];
          next_state.flow.port2_tx_pause_enable = req.wdata[psdl_pkg::BIT_TXFC];
          next_state.flow.port2_rx_pause_enable = req.wdata[psdl_pkg::BIT_RXFC];
          next_state.flow.port2_manual_flow_select = req.wdata[psdl_pkg::BIT_MANUAL];
        end
        default: ;
      endcase
    end
    // fallback speed only matters when negotiation failed; else keep strap view
    if (cap_loaded && port0_aneg_failed) begin
      next_state.p0_speed = straps.p0_speed; // R7
    end else if (cap_loaded && !state.seeded) begin
      next_state.p0_speed = straps.p0_speed;
    end
    next_state.rdata = psdl_pkg::RD_ZERO;
    if (req.rd) begin
      unique case (req.addr)
        psdl_pkg::OFS_P2_BASIC:  next_state.rdata = {14'h0000, state.basic.duplex_mode_bit,
                                                     state.basic.rate_select_low_bit};
        psdl_pkg::OFS_P2_FLOW:   next_state.rdata = {12'h000, state.flow};
        psdl_pkg::OFS_P0_STATUS: next_state.rdata = {14'h0000, state.p0_full, state.p0_speed};
        psdl_pkg::OFS_P0_LPABIL: next_state.rdata = {12'h000, state.ability};
        psdl_pkg::OFS_STRAPS:    next_state.rdata = {8'h00, state.loaded, straps};
        default:                 next_state.rdata = psdl_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs straight from state flops
  assign rdata                       = state.rdata;
  assign port2_basic_control_reg     = state.basic;
  assign port2_flow                  = state.flow;
  assign port0_speed_100             = state.p0_speed;
  assign port0_full_duplex           = state.p0_full;
  assign virtual_partner_ability_reg = state.ability;
  assign straps_loaded               = state.seeded;

endmodule

/* hw/psdl_pkg.sv */
package psdl_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [3:0] OFS_P2_BASIC  = 4'h0;
  localparam logic [3:0] OFS_P2_FLOW   = 4'h1;
  localparam logic [3:0] OFS_P0_STATUS = 4'h2;
  localparam logic [3:0] OFS_P0_LPABIL = 4'h3;
  localparam logic [3:0] OFS_STRAPS    = 4'h4;

  // ==========================================================================
  // field positions
  localparam int BIT_RATE    = 0;
  localparam int BIT_DUPLEX  = 1;
  localparam int BIT_BP      = 0;
  localparam int BIT_TXFC    = 1;
  localparam int BIT_RXFC    = 2;
  localparam int BIT_MANUAL  = 3;
  localparam int BIT_AB_10H  = 0;
  localparam int BIT_AB_10F  = 1;
  localparam int BIT_AB_100H = 2;
  localparam int BIT_AB_100F = 3;

  localparam logic [15:0] RD_ZERO = 16'h0000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic p2_speed;
    logic p2_duplex;
    logic p2_backpressure;
    logic p2_pause;
    logic p2_manual_flow;
    logic p0_speed;
    logic p0_duplex_polarity;
  } psdl_straps_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } psdl_req_t;

  typedef struct packed {
    logic       rate_select_low_bit;
    logic       duplex_mode_bit;
  } psdl_basic_t;

  typedef struct packed {
    logic port2_manual_flow_select;
    logic port2_rx_pause_enable;
    logic port2_tx_pause_enable;
    logic port2_backpressure_enable;
  } psdl_flow_t;

endpackage

/* hw/psdl_capture.sv */
`timescale 1ns/1ps
module psdl_capture (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // strap pins
  input  wire psdl_pkg::psdl_straps_t straps_in,
  // captured levels
  output psdl_pkg::psdl_straps_t     straps,
  output logic                       loaded
);

  typedef struct packed {
    psdl_pkg::psdl_straps_t straps;
    logic                   loaded;
  } psdl_cap_state_t;

  psdl_cap_state_t state;
  psdl_cap_state_t next_state;

  // ==========================================================================
  // one-shot sample in first clock after reset release
  always_comb begin
    next_state = state;
    if (!state.loaded) begin
      next_state.straps = straps_in; // R9
      next_state.loaded = 1'b1;
    end
  end

  // async reset loads constants only; straps taken by the clocked path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign straps = state.straps;
  assign loaded = state.loaded;

endmodule

/* hw/psdl_ability.sv */
`timescale 1ns/1ps
module psdl_ability (
  // captured speed strap and decoded duplex
  input  wire logic       speed_strap,
  input  wire logic       duplex_full,
  // virtual partner ability bits
  output logic      [3:0] ability
);

  // ==========================================================================
  // single advertised mode from speed and decoded duplex
  always_comb begin
    ability = 4'h0;
    unique case ({speed_strap, duplex_full})
      2'b00: ability[psdl_pkg::BIT_AB_10H]  = 1'b1; // R6
      2'b01: ability[psdl_pkg::BIT_AB_10F]  = 1'b1;
      2'b10: ability[psdl_pkg::BIT_AB_100H] = 1'b1;
      2'b11: ability[psdl_pkg::BIT_AB_100F] = 1'b1;
    endcase
  end

endmodule

/* dv/psdl_board.sv */
`timescale 1ns/1ps
module psdl_board (
  // jumpers, z leaves the pull-up in charge
  input  wire logic [6:0]        jumper,
  // strap pins
  output psdl_pkg::psdl_straps_t straps_in
);
  // every strap has a pull-up, so an open jumper reads high
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      straps_in[i] = (jumper[i] === 1'b0) ? 1'b0 : 1'b1;
    end
  end
endmodule

/* dv/psdl_loader_sva.sv */
`timescale 1ns/1ps
module psdl_loader_sva (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rstn,
  // watched ports
  input wire logic                  port0_duplex_pin,
  input wire psdl_pkg::psdl_req_t   req,
  input wire logic [15:0]           rdata,
  input wire psdl_pkg::psdl_basic_t port2_basic_control_reg,
  input wire psdl_pkg::psdl_flow_t  port2_flow,
  input wire logic                  port0_speed_100,
  input wire logic                  port0_full_duplex,
  input wire logic [3:0]            virtual_partner_ability_reg,
  input wire logic                  straps_loaded
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_rdata_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("rdata not idle");
  chk_loaded_hold: assert property (straps_loaded |=> straps_loaded)
    else $error("loaded dropped");
  chk_dup_follow: assert property (straps_loaded && $changed(port0_duplex_pin) |=>
    $changed(port0_full_duplex))
    else $error("duplex decode");
  chk_abil_hot: assert property ($past(straps_loaded) |->
    $onehot(virtual_partner_ability_reg))
    else $error("ability not one-hot");
  chk_abil_speed: assert property ($past(straps_loaded) |->
    (virtual_partner_ability_reg[3] | virtual_partner_ability_reg[2]) == port0_speed_100)
    else $error("ability speed");
  chk_speed_hold: assert property ($past(straps_loaded) |-> $stable(port0_speed_100))
    else $error("speed moved");
  chk_basic_hold: assert property ($past(straps_loaded) && !$past(req.wr)
    |-> $stable(port2_basic_control_reg))
    else $error("basic moved");
  chk_flow_write: assert property (straps_loaded && req.wr
    && req.addr == psdl_pkg::OFS_P2_FLOW |=> port2_flow == $past(req.wdata[3:0]))
    else $error("flow write");
  cover property (straps_loaded && req.wr);
  cover property (straps_loaded && $changed(port0_duplex_pin));
  cover property (req.rd && req.addr == psdl_pkg::OFS_P0_LPABIL);
endmodule
bind psdl_loader psdl_loader_sva u_sva (.sys_clk, .rstn, .port0_duplex_pin, .req, .rdata,
  .port2_basic_control_reg, .port2_flow, .port0_speed_100, .port0_full_duplex,
  .virtual_partner_ability_reg, .straps_loaded);

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic                   sys_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic [6:0]             jumper = 7'h00;
  logic                   dpin = 1'b0;
  logic                   aneg_bad = 1'b0;
  psdl_pkg::psdl_req_t    req = '0;
  psdl_pkg::psdl_straps_t straps;
  psdl_pkg::psdl_flow_t   flow;
  psdl_pkg::psdl_basic_t  basic;
  logic [3:0]             abil;
  logic [15:0]            rdata;
  logic                   spd;
  logic                   full;
  logic                   loaded;
  int                     mismatches = 0;
  int                     checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  psdl_board u_board (.jumper(jumper), .straps_in(straps));
  psdl_loader u_dut (.sys_clk(sys_clk), .rstn(rstn), .straps_in(straps),
    .port0_duplex_pin(dpin), .port0_aneg_failed(aneg_bad), .req(req), .rdata(rdata),
    .port2_basic_control_reg(basic), .port2_flow(flow), .port0_speed_100(spd),
    .port0_full_duplex(full), .virtual_partner_ability_reg(abil), .straps_loaded(loaded));
  task automatic test_done();
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    req <= '0;
    // let an edge pass so a following call never reassigns req in this step
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1 cmp(rdata, e);
    @(posedge sys_clk);
  endtask
  task automatic t_defaults(input logic [6:0] j, input logic pin);
    logic fd;
    fd = (pin == j[0]);
    dpin <= pin;
    jumper <= j;
    rstn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int n = 0; n < 10 && loaded !== 1'b1; n++) @(posedge sys_clk);
    if (loaded !== 1'b1) begin
      mismatches++;
      test_done();
    end
    #1 cmp({12'h0, abil}, 16'h0001 << {j[1], fd});
    cmp({14'h0, basic}, {14'h0, j[6], j[5]});
    @(posedge sys_clk);
    rdc(psdl_pkg::OFS_P2_BASIC, {14'h0, j[5], j[6]});
    rdc(psdl_pkg::OFS_P2_FLOW, {12'h0, j[2], j[3], j[3], j[4]});
    rdc(psdl_pkg::OFS_P0_STATUS, {14'h0, fd, j[1]});
    rdc(psdl_pkg::OFS_P0_LPABIL, 16'h0001 << {j[1], fd});
    rdc(psdl_pkg::OFS_STRAPS, {8'h00, 1'b1, j});
  endtask
  // straps and pin move after capture: only the live duplex decode may follow
  task automatic t_late();
    jumper <= 7'h00;
    dpin <= 1'b0;
    aneg_bad <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 cmp({14'h0, full, spd}, 16'h0001);
    @(posedge sys_clk);
    rdc(psdl_pkg::OFS_STRAPS, 16'h00FF);
    rdc(psdl_pkg::OFS_P2_BASIC, 16'h0003);
  endtask
  task automatic t_writes();
    wr(psdl_pkg::OFS_P2_FLOW, 16'hFFFA);
    wr(psdl_pkg::OFS_P2_BASIC, 16'h0002);
    wr(psdl_pkg::OFS_STRAPS, 16'h0000);
    #1 cmp({12'h0, flow}, 16'h000A);
    @(posedge sys_clk);
    rdc(psdl_pkg::OFS_P2_BASIC, 16'h0002);
    rdc(4'hF, 16'h0000);
    rdc(psdl_pkg::OFS_STRAPS, 16'h00FF);
  endtask
  initial begin
    t_defaults(7'h00, 1'b0);
    t_defaults(7'h55, 1'b0);
    t_defaults(7'h2A, 1'b1);
    t_defaults(7'h7F, 1'b1);
    t_late();
    t_writes();
    test_done();
  end
endmodule
